// File: sacr_analog_src.sv
// partner model: analog sources behind the mux and the convert strobe
// assumes mux selects and track come straight from the control block
`timescale 1ns/1ps
module sacr_analog_src (
  input wire logic clock_in,
  input wire logic [3:0] mux_pos_in,
  input wire logic differential_in,
  input wire logic temp_sel_in,
  input wire logic track_in,
  input wire logic strobe_req_in,
  output logic [11:0] code_out,
  output logic strobe_out
);
  logic [11:0] level;
  logic [3:0] low_cnt_q = 4'h0;
  ////////////////////////////////////////
  // one distinct level per source, negative for pairs
  assign level = temp_sel_in ? 12'h5A5 : differential_in ? {8'hF0, mux_pos_in} : {mux_pos_in, 8'h3C};
  // while tracking the held value is not final, so show garbage
  assign code_out = track_in ? ~level : level;
  // strobe idles high, held low eight clocks per request
  always_ff @(posedge clock_in) begin
    if (strobe_req_in) begin
      low_cnt_q <= 4'h8;
    end else if (low_cnt_q != 4'h0) begin
      low_cnt_q <= low_cnt_q - 4'h1;
    end
  end
  assign strobe_out = (low_cnt_q == 4'h0);
endmodule

// File: sacr_pkg.sv
// shared constants and types for the converter control block
// assumes a byte-wide special-function-register bus on one clock
package sacr_pkg;
  localparam logic [7:0] SACR_ADDR_PAIR_CFG = 8'hBA;
  localparam logic [7:0] SACR_ADDR_CHAN_SEL = 8'hBB;
  localparam logic [7:0] SACR_ADDR_CONV_CFG = 8'hBC;
  localparam logic [7:0] SACR_ADDR_RES_HI = 8'hBF;
  localparam logic [7:0] SACR_ADDR_RES_LO = 8'hBE;
  localparam logic [7:0] SACR_ADDR_CTRL = 8'hE8;
  localparam logic [7:0] SACR_RST_PAIR_CFG = 8'h00;
  localparam logic [7:0] SACR_RST_CHAN_SEL = 8'h00;
  localparam logic [7:0] SACR_RST_CONV_CFG = 8'hF8;
  localparam logic [7:0] SACR_RST_CTRL = 8'h00;
  localparam logic [7:0] SACR_RST_RES = 8'h00;
  // control register bit positions
  localparam int SACR_BIT_EN = 7;
  localparam int SACR_BIT_TM = 6;
  localparam int SACR_BIT_DONE = 5;
  localparam int SACR_BIT_BUSY = 4;
  localparam int SACR_BIT_CM1 = 3;
  localparam int SACR_BIT_CM0 = 2;
  localparam int SACR_BIT_WIN = 1;
  localparam int SACR_BIT_LJST = 0;
  // config register field positions
  localparam int SACR_DIV_LSB = 3;
  localparam int SACR_GAIN_LSB = 0;
  // cycle counts in sar clocks
  localparam logic [4:0] SACR_TRACK_SAR_CLKS = 5'h0_3;
  localparam logic [4:0] SACR_CONV_SAR_CLKS = 5'h1_0;
  localparam int SACR_RES_W = 12;
  typedef enum logic [1:0] {
    SACR_SRC_SOFT = 2'h0,
    SACR_SRC_TMR3 = 2'h1,
    SACR_SRC_STROBE = 2'h2,
    SACR_SRC_TMR2 = 2'h3
  } sacr_src_t;
  typedef enum logic [3:0] {
    SACR_ST_IDLE = 4'h1,
    SACR_ST_TRACK = 4'h2,
    SACR_ST_CONV = 4'h4,
    SACR_ST_STRB = 4'h8
  } sacr_state_t;
  typedef struct packed {
    logic [3:0] mux_pos;
    logic [3:0] mux_neg;
    logic temp_sel;
    logic differential;
    logic [2:0] gain_code;
  } sacr_mux_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sacr_bus_t;
endpackage

// File: sacr_sar_div.sv
// sar clock enable divider
// assumes the divider value is stable while enabled
`timescale 1ns/1ps
module sacr_sar_div #(
  parameter int DIV_W = 5
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [DIV_W-1:0] div_in,
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_q;
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else if (cnt_q >= div_in) begin
      cnt_q <= '0;
      tick_out <= 1'b1; // see RULE10
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule

// File: sacr_top.sv
// register file, start logic, sequencer and result formatting
// assumes the analog core hands a 12-bit code when the sequence ends
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Contract
// RULE1 - each pair bit: 0 two single-ended inputs, 1 differential even+/odd-
// RULE2 - differential results are two's complement, single-ended unsigned (right justify repeats bit 11 in the high nibble for single-ended too)
// RULE3 - four-bit address picks input; 1xxx selects temperature sensor
// RULE4 - sar clock comes from system clock via config bits 7..3
// RULE5 - gain field: 000=1,001=2,010=4,011=8,10x=16,11x=0.5 (gain_x2_out gives 5'h1F, 15.5, for 10x)
// RULE6 - low-power tracking: three sar clocks of tracking before each conversion
// RULE7 - right justify: result in high low nibble and full low byte
// RULE8 - right justify: high byte upper nibble repeats result bit 11
// RULE9 - left justify: eight msbs high, four lsbs low upper nibble, zeros
// RULE10 - sar period is system period times divider plus one
// RULE11 - converter, hold and amplifier run only while enable is set
// RULE12 - busy high while converting; its fall sets done flag
// RULE13 - two-bit source: soft busy write, timer3, strobe rise, timer2
// RULE14 - low-power with strobe: track while strobe low, convert on rise
module sacr_top
  import sacr_pkg::*;
#(
  parameter int RES_W = SACR_RES_W
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  input wire logic timer3_ovf_in,
  input wire logic timer2_ovf_in,
  input wire logic external_convert_strobe_in,
  input wire logic [RES_W-1:0] core_code_in,
  input wire logic window_hit_in,
  output logic analog_enable_out,
  output logic track_out,
  output logic sar_step_out,
  output logic [3:0] mux_pos_out,
  output logic [3:0] mux_neg_out,
  output logic temp_sel_out,
  output logic differential_out,
  output logic [2:0] gain_code_out,
  output logic [4:0] gain_x2_out,
  output logic done_pulse_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] pair_cfg_q;
  logic [7:0] chan_sel_q;
  logic [7:0] conv_cfg_q;
  logic [7:0] ctrl_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  sacr_state_t state_q;
  logic [4:0] step_q;
  logic strb_s1_q;
  logic strb_s2_q;
  logic strb_d_q;
  logic sar_tick;
  logic start;
  logic strb_rise;
  logic conv_end;
  logic wr_ctrl;
  sacr_src_t src;
  sacr_mux_t mux_d;
  logic [RES_W-1:0] code;

  assign src = sacr_src_t'(ctrl_q[SACR_BIT_CM1:SACR_BIT_CM0]);
  assign wr_ctrl = bus_wr_in && (bus_addr_in == SACR_ADDR_CTRL);
  assign strb_rise = strb_s2_q && !strb_d_q;
  assign conv_end = (state_q == SACR_ST_CONV) && sar_tick && (step_q == SACR_CONV_SAR_CLKS - 5'h0_1);

  ////////////////////////////////////////////////////////////////////////
  // strobe pin synchroniser; only the second stage feeds logic
  // reset to the idle-high level so release of reset shows no false rise
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      strb_s1_q <= 1'b1;
      strb_s2_q <= 1'b1;
      strb_d_q <= 1'b1;
    end else begin
      strb_s1_q <= external_convert_strobe_in;
      strb_s2_q <= strb_s1_q;
      strb_d_q <= strb_s2_q;
    end
  end

  always_comb begin
    case (src) // see RULE13
      SACR_SRC_SOFT: start = wr_ctrl && bus_wdata_in[SACR_BIT_BUSY];
      SACR_SRC_TMR3: start = timer3_ovf_in;
      SACR_SRC_STROBE: start = strb_rise;
      SACR_SRC_TMR2: start = timer2_ovf_in;
      default: start = 1'b0;
    endcase
  end

  sacr_sar_div #(
    .DIV_W(5)
  ) u_div (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .run_in(ctrl_q[SACR_BIT_EN] && (state_q != SACR_ST_IDLE) && (state_q != SACR_ST_STRB)),
    .div_in(conv_cfg_q[7:SACR_DIV_LSB]), // see RULE4
    .tick_out(sar_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer; starts while busy are ignored rather than restarting
  always_ff @(posedge clock_in) begin
    if (rst_in || !ctrl_q[SACR_BIT_EN]) begin // see RULE11
      state_q <= SACR_ST_IDLE;
      step_q <= 5'h0_0;
    end else begin
      case (state_q)
        SACR_ST_IDLE: begin
          step_q <= 5'h0_0;
          if (ctrl_q[SACR_BIT_TM] && src == SACR_SRC_STROBE && !strb_s2_q) begin
            state_q <= SACR_ST_STRB; // see RULE14
          end else if (start) begin
            state_q <= ctrl_q[SACR_BIT_TM] ? SACR_ST_TRACK : SACR_ST_CONV;
          end
        end
        SACR_ST_STRB: begin
          if (strb_rise) begin
            state_q <= SACR_ST_CONV; // see RULE14
          end else if (!ctrl_q[SACR_BIT_TM] || src != SACR_SRC_STROBE) begin
            state_q <= SACR_ST_IDLE;
          end
        end
        SACR_ST_TRACK: begin
          if (sar_tick) begin
            if (step_q == SACR_TRACK_SAR_CLKS - 5'h0_1) begin
              step_q <= 5'h0_0;
              state_q <= SACR_ST_CONV; // see RULE6
            end else begin
              step_q <= step_q + 5'h0_1;
            end
          end
        end
        SACR_ST_CONV: begin
          if (sar_tick) begin
            if (conv_end) begin
              step_q <= 5'h0_0;
              state_q <= SACR_ST_IDLE;
            end else begin
              step_q <= step_q + 5'h0_1;
            end
          end
        end
        default: begin
          state_q <= SACR_ST_IDLE;
          step_q <= 5'h0_0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pair_cfg_q <= SACR_RST_PAIR_CFG;
      chan_sel_q <= SACR_RST_CHAN_SEL;
      conv_cfg_q <= SACR_RST_CONV_CFG;
    end else if (bus_wr_in) begin
      if (bus_addr_in == SACR_ADDR_PAIR_CFG) pair_cfg_q <= {4'h0, bus_wdata_in[3:0]};
      if (bus_addr_in == SACR_ADDR_CHAN_SEL) chan_sel_q <= {4'h0, bus_wdata_in[3:0]};
      if (bus_addr_in == SACR_ADDR_CONV_CFG) conv_cfg_q <= bus_wdata_in;
    end
  end

  // control register; hardware set of done and window wins over a clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl_q <= SACR_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[SACR_BIT_EN] <= bus_wdata_in[SACR_BIT_EN];
        ctrl_q[SACR_BIT_TM] <= bus_wdata_in[SACR_BIT_TM];
        ctrl_q[SACR_BIT_CM1:SACR_BIT_CM0] <= bus_wdata_in[SACR_BIT_CM1:SACR_BIT_CM0];
        ctrl_q[SACR_BIT_LJST] <= bus_wdata_in[SACR_BIT_LJST];
        ctrl_q[SACR_BIT_DONE] <= bus_wdata_in[SACR_BIT_DONE];
        ctrl_q[SACR_BIT_WIN] <= bus_wdata_in[SACR_BIT_WIN];
      end
      if (conv_end) begin
        ctrl_q[SACR_BIT_DONE] <= 1'b1; // see RULE12
        if (window_hit_in) ctrl_q[SACR_BIT_WIN] <= 1'b1;
      end
      ctrl_q[SACR_BIT_BUSY] <= (state_q == SACR_ST_TRACK) || (state_q == SACR_ST_CONV)
        ? !conv_end : (start && ctrl_q[SACR_BIT_EN] && state_q == SACR_ST_IDLE); // see RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result formatting on completion
  assign code = core_code_in;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      res_hi_q <= SACR_RST_RES;
      res_lo_q <= SACR_RST_RES;
    end else if (conv_end) begin
      if (ctrl_q[SACR_BIT_LJST]) begin
        res_hi_q <= code[11:4]; // see RULE9
        res_lo_q <= {code[3:0], 4'h0};
      end else begin
        res_hi_q <= {{4{code[11]}}, code[11:8]}; // see RULE7 see RULE8 see RULE2
        res_lo_q <= code[7:0]; // see RULE7
      end
    end else if (bus_wr_in) begin
      if (bus_addr_in == SACR_ADDR_RES_HI) res_hi_q <= bus_wdata_in;
      if (bus_addr_in == SACR_ADDR_RES_LO) res_lo_q <= bus_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // multiplexer steering from pair config and channel address
  always_comb begin
    mux_d.temp_sel = chan_sel_q[3]; // see RULE3
    mux_d.differential = !chan_sel_q[3] && pair_cfg_q[chan_sel_q[2:1]]; // see RULE1
    mux_d.mux_pos = {1'b0, chan_sel_q[2:0]};
    mux_d.mux_neg = 4'hF;
    if (mux_d.differential) begin
      mux_d.mux_pos = {1'b0, chan_sel_q[2:1], 1'b0}; // see RULE3
      mux_d.mux_neg = {1'b0, chan_sel_q[2:1], 1'b1};
    end
    mux_d.gain_code = conv_cfg_q[SACR_GAIN_LSB+2:SACR_GAIN_LSB];
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mux_pos_out <= 4'h0;
      mux_neg_out <= 4'hF;
      temp_sel_out <= 1'b0;
      differential_out <= 1'b0;
      gain_code_out <= 3'h0;
      gain_x2_out <= 5'h0_2;
      analog_enable_out <= 1'b0;
      track_out <= 1'b0;
      sar_step_out <= 1'b0;
      done_pulse_out <= 1'b0;
      bus_rdata_out <= 8'h0_0;
    end else begin
      mux_pos_out <= mux_d.mux_pos;
      mux_neg_out <= mux_d.mux_neg;
      temp_sel_out <= mux_d.temp_sel;
      differential_out <= mux_d.differential; // see RULE2
      gain_code_out <= mux_d.gain_code;
      casez (mux_d.gain_code) // see RULE5
        3'b000: gain_x2_out <= 5'h0_2;
        3'b001: gain_x2_out <= 5'h0_4;
        3'b010: gain_x2_out <= 5'h0_8;
        3'b011: gain_x2_out <= 5'h1_0;
        3'b10?: gain_x2_out <= 5'h1_F;
        default: gain_x2_out <= 5'h0_1;
      endcase
      analog_enable_out <= ctrl_q[SACR_BIT_EN]; // see RULE11
      // default mode tracks whenever idle; low-power only in its window
      track_out <= ctrl_q[SACR_BIT_EN] && ((state_q == SACR_ST_TRACK) || (state_q == SACR_ST_STRB)
        || (state_q == SACR_ST_IDLE && !ctrl_q[SACR_BIT_TM]));
      sar_step_out <= sar_tick && (state_q == SACR_ST_CONV);
      done_pulse_out <= conv_end; // see RULE12
      bus_rdata_out <= 8'h0_0;
      if (bus_rd_in) begin
        case (bus_addr_in)
          SACR_ADDR_PAIR_CFG: bus_rdata_out <= pair_cfg_q;
          SACR_ADDR_CHAN_SEL: bus_rdata_out <= chan_sel_q;
          SACR_ADDR_CONV_CFG: bus_rdata_out <= conv_cfg_q;
          SACR_ADDR_CTRL: bus_rdata_out <= ctrl_q;
          SACR_ADDR_RES_HI: bus_rdata_out <= res_hi_q;
          SACR_ADDR_RES_LO: bus_rdata_out <= res_lo_q;
          default: bus_rdata_out <= 8'h0_0;
        endcase
      end
    end
  end
endmodule

// File: sacr_top_props.sv
// port checker for the converter control block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sacr_top_props (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic analog_enable_out,
  input wire logic track_out,
  input wire logic sar_step_out,
  input wire logic [3:0] mux_pos_out,
  input wire logic [3:0] mux_neg_out,
  input wire logic temp_sel_out,
  input wire logic differential_out,
  input wire logic [2:0] gain_code_out,
  input wire logic [4:0] gain_x2_out,
  input wire logic done_pulse_out
);
  logic [4:0] steps_q;
  ////////////////////////////////////////
  // aborts by disable restart the count
  always_ff @(posedge clock_in) begin
    if (rst_in || done_pulse_out || !analog_enable_out) begin
      steps_q <= 5'h00;
    end else if (sar_step_out) begin
      steps_q <= steps_q + 5'h01;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_step_needs_en: assert property (sar_step_out |-> analog_enable_out)
    else $error("sar step while disabled");
  a_no_step_track: assert property (sar_step_out |-> !track_out)
    else $error("sar step while tracking");
  a_gain_map: assert property (gain_x2_out == (gain_code_out[2] ? (gain_code_out[1] ? 5'h01 : 5'h1F)
    : 5'h02 << gain_code_out[1:0])) else $error("gain value wrong");
  a_diff_pair: assert property (differential_out |-> !mux_pos_out[0] && mux_neg_out == mux_pos_out + 4'h1)
    else $error("pair selects wrong");
  a_single_gnd: assert property (!differential_out |-> mux_neg_out == 4'hF)
    else $error("single input not to ground");
  a_temp_single: assert property (temp_sel_out |-> !differential_out)
    else $error("sensor taken as pair");
  a_sixteen_steps: assert property (done_pulse_out |-> steps_q + {4'h0, sar_step_out} == 5'h10)
    else $error("step count wrong at end");
  a_done_one: assert property (done_pulse_out |=> !done_pulse_out)
    else $error("end pulse too long");
endmodule

// File: test_sar_adc_control_regs.sv
// self-checking bench for the converter control block
// assumes the analog source model on the far side
`timescale 1ns/1ps
module test_sar_adc_control_regs;
  import sacr_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  logic timer3_ovf_in = 1'b0;
  logic timer2_ovf_in = 1'b0;
  logic window_hit_in = 1'b0;
  logic strobe_req = 1'b0;
  logic [7:0] bus_addr_in = 8'h00;
  logic [7:0] bus_wdata_in = 8'h00;
  logic [7:0] bus_rdata_out;
  logic [11:0] core_code_in;
  logic external_convert_strobe_in, analog_enable_out, track_out, sar_step_out;
  logic temp_sel_out, differential_out, done_pulse_out;
  logic [3:0] mux_pos_out, mux_neg_out;
  logic [2:0] gain_code_out;
  logic [4:0] gain_x2_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc;
  sacr_top dut (.clock_in(clock_in), .rst_in(rst_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
    .timer3_ovf_in(timer3_ovf_in), .timer2_ovf_in(timer2_ovf_in),
    .external_convert_strobe_in(external_convert_strobe_in), .core_code_in(core_code_in),
    .window_hit_in(window_hit_in), .analog_enable_out(analog_enable_out), .track_out(track_out),
    .sar_step_out(sar_step_out), .mux_pos_out(mux_pos_out), .mux_neg_out(mux_neg_out),
    .temp_sel_out(temp_sel_out), .differential_out(differential_out), .gain_code_out(gain_code_out),
    .gain_x2_out(gain_x2_out), .done_pulse_out(done_pulse_out));
  sacr_analog_src src (.clock_in(clock_in), .mux_pos_in(mux_pos_out), .differential_in(differential_out),
    .temp_sel_in(temp_sel_out), .track_in(track_out), .strobe_req_in(strobe_req), .code_out(core_code_in),
    .strobe_out(external_convert_strobe_in));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  ////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus_wr_in <= 1'b1;
    bus_addr_in <= a;
    bus_wdata_in <= d;
    @(posedge clock_in);
    bus_wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    bus_rd_in <= 1'b1;
    bus_addr_in <= a;
    @(posedge clock_in);
    bus_rd_in <= 1'b0;
    #1;
    chk(what, {8'h00, e}, {8'h00, bus_rdata_out});
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rd_chk("pair cfg", SACR_ADDR_PAIR_CFG, 8'h00);
    rd_chk("chan sel", SACR_ADDR_CHAN_SEL, 8'h00);
    rd_chk("conv cfg", SACR_ADDR_CONV_CFG, 8'hF8);
    rd_chk("ctrl", SACR_ADDR_CTRL, 8'h00);
    rd_chk("res lo", SACR_ADDR_RES_LO, 8'h00);
    rd_chk("unmapped", 8'hC0, 8'h00);
    chk("gain x2", 16'h0002, {11'h000, gain_x2_out});
    $display("test reset done");
  endtask
  task automatic t_gain;
    logic [4:0] exp;
    for (int g = 0; g < 8; g++) begin
      exp = g[2] ? (g[1] ? 5'h01 : 5'h1F) : 5'h02 << g[1:0];
      wr_reg(SACR_ADDR_CONV_CFG, {5'h00, g[2:0]});
      repeat (2) @(posedge clock_in);
      #1;
      chk("gain code", {13'h0000, g[2:0]}, {13'h0000, gain_code_out});
      chk("gain x2", {11'h000, exp}, {11'h000, gain_x2_out});
    end
    $display("test gain done");
  endtask
  // one conversion from any source; sar rate, low-power tracking and strobe delay decide the window
  task automatic t_conv(input logic [7:0] pair, input logic [7:0] chan, input logic [7:0] cfg,
    input logic [7:0] ctrl, input logic [1:0] s, input logic [15:0] exp, input logic [9:0] mx,
    input int lo, input int hi);
    wr_reg(SACR_ADDR_PAIR_CFG, pair);
    wr_reg(SACR_ADDR_CHAN_SEL, chan);
    wr_reg(SACR_ADDR_CONV_CFG, cfg);
    // enable and source must stand before the start write is decoded
    wr_reg(SACR_ADDR_CTRL, ctrl & 8'hEF);
    wr_reg(SACR_ADDR_CTRL, ctrl);
    timer3_ovf_in <= (s == 2'h1);
    strobe_req <= (s == 2'h2);
    timer2_ovf_in <= (s == 2'h3);
    cyc = 0;
    while (done_pulse_out !== 1'b1 && cyc < 400) begin
      @(posedge clock_in);
      timer3_ovf_in <= 1'b0;
      strobe_req <= 1'b0;
      timer2_ovf_in <= 1'b0;
      #1;
      cyc++;
    end
    chk("conv time", 16'h0001, {15'h0000, cyc >= lo && cyc <= hi});
    if (mx !== 10'h3FF) begin
      chk("mux", {6'h00, mx}, {6'h00, mux_pos_out, mux_neg_out, temp_sel_out, differential_out});
    end
    rd_chk("res hi", SACR_ADDR_RES_HI, exp[15:8]);
    rd_chk("res lo", SACR_ADDR_RES_LO, exp[7:0]);
    rd_chk("ctrl done", SACR_ADDR_CTRL, ctrl & 8'hEF | 8'h20);
    $display("test conversion done");
  endtask
  task automatic t_idle(input logic [7:0] ctrl);
    int seen = 0;
    wr_reg(SACR_ADDR_CTRL, ctrl & 8'hEF);
    wr_reg(SACR_ADDR_CTRL, ctrl);
    repeat (40) begin
      @(posedge clock_in);
      #1;
      if (done_pulse_out === 1'b1) seen++;
    end
    chk("no conv", 16'h0000, seen[15:0]);
    rd_chk("ctrl idle", SACR_ADDR_CTRL, ctrl & 8'hEF);
    $display("test refusal done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_gain();
    t_conv(8'h00, 8'h02, 8'h00, 8'h90, 2'h0, 16'h023C, 10'h0BC, 16, 21);
    t_conv(8'h00, 8'h02, 8'h18, 8'h91, 2'h0, 16'h23C0, 10'h0BC, 64, 72);
    t_conv(8'h01, 8'h00, 8'h00, 8'h90, 2'h0, 16'hFF00, 10'h005, 16, 21);
    t_conv(8'h08, 8'h06, 8'h00, 8'h91, 2'h0, 16'hF060, 10'h19D, 16, 21);
    t_conv(8'h00, 8'h0F, 8'h00, 8'h90, 2'h0, 16'h05A5, 10'h3FF, 16, 21);
    t_conv(8'h00, 8'h02, 8'h08, 8'hD0, 2'h0, 16'h023C, 10'h0BC, 38, 44);
    t_conv(8'h00, 8'h02, 8'h00, 8'h84, 2'h1, 16'h023C, 10'h0BC, 16, 21);
    t_conv(8'h00, 8'h02, 8'h00, 8'h8C, 2'h3, 16'h023C, 10'h0BC, 16, 21);
    t_conv(8'h00, 8'h02, 8'h00, 8'hC8, 2'h2, 16'h023C, 10'h0BC, 16, 40);
    t_idle(8'h10);
    t_idle(8'h94);
    stop_test();
  end
  // whole run needs well under two thousand clocks
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
bind sacr_top sacr_top_props props (.clock_in(clock_in), .rst_in(rst_in), .analog_enable_out(analog_enable_out),
  .track_out(track_out), .sar_step_out(sar_step_out), .mux_pos_out(mux_pos_out), .mux_neg_out(mux_neg_out),
  .temp_sel_out(temp_sel_out), .differential_out(differential_out), .gain_code_out(gain_code_out),
  .gain_x2_out(gain_x2_out), .done_pulse_out(done_pulse_out));
